// >>> hdl/pbr_regs.sv
/*
 Basic control and status registers of the transceiver with their serial management slave.
 Assumes the management clock pin is far slower than mclk, the auto-negotiation and link
 engines run on mclk, and the pad ring resolves the management data wire from mdio_oe_n.
*/
`timescale 1ns/1ps
// What this block does
// - Writing control bit 15 starts soft reset; bit clears itself when done.
// - After soft reset completes, no power down, no isolation, no loopback.
// - Forced speed from bits 6 and 13: 00 10M, 01 100M, 10 1000M.
// - With auto-negotiation enabled, speed and duplex bits ignored; negotiated result used.
// - Speed select high bit 6 is read-only; writes do nothing.
// - Speed, auto-negotiation enable and duplex reset values come from mode straps.
// - Control bit 11 set enters power down; clearing returns to normal.
// - Control bit 10 isolates the MAC-side interface; resets to zero.
// - Writing control bit 9 restarts auto-negotiation; bit clears itself.
// - Status bits 14 to 11 always read one.
// - Status bits 15, 10 and 9 always read zero.
// - Status bit 8 always reads one for extended status.
// - Status bit 3 always reads one for auto-negotiation ability.
// - Status bit 0 always reads one for extended capabilities.
// - Status bit 5 shows auto-negotiation complete, read straight from an_complete with no latch or reset.
// - Status bit 4 latches high on remote fault; resets to zero.
// - Status bit 2 shows link, holding a link loss until read.
// - Status bit 1 latches high on jabber; resets to zero.
// - Latch-high bit holds until read, then falls only once cause is gone.
// - A read of the register releases a latched-low bit.
// - Registers reached over serial management bus, selected by index.
module pbr_regs
   import pbr_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       mdc,
   input  wire logic       mdio_in,
   output logic            mdio_out,
   output logic            mdio_oe_n,
   input  wire logic [4:0] phy_addr,
   input  wire logic [1:0] mode_cfg,
   input  wire logic       an_complete,
   input  wire logic [1:0] an_speed,
   input  wire logic       an_full_duplex,
   input  wire logic       remote_fault,
   input  wire logic       link_up,
   input  wire logic       jabber,
   output logic            phy_soft_reset,
   output logic            loopback_en,
   output logic            power_down,
   output logic            isolate_mac,
   output logic            an_enable,
   output logic            an_restart,
   output logic [1:0]      op_speed,
   output logic            op_full_duplex
);

   // Pin inputs pass two flip-flops before use
   logic [8:0]   pins_s;
   logic         mdc_s;
   logic         mdio_s;
   logic [4:0]   addr_s;
   logic [1:0]   cfg_s;

   pbr_sync2 #(.WIDTH(9)) u_sync (
      .mclk     (mclk),
      .rst      (rst),
      .async_in ({mdc, mdio_in, phy_addr, mode_cfg}),
      .sync_out (pins_s)
   );

   assign mdc_s  = pins_s[8];
   assign mdio_s = pins_s[7];
   assign addr_s = pins_s[6:2];
   assign cfg_s  = pins_s[1:0];

   // Strap decode: {speed msb, speed lsb, an enable, duplex}
   function automatic logic [3:0] strap_decode(input logic [1:0] cfg);
      logic [3:0] res;
      res = 4'h0;
      unique case (cfg)
         2'h0: res = {SPD_10, 1'b0, 1'b0};
         2'h1: res = {SPD_100, 1'b0, 1'b0};
         2'h2: res = {SPD_100, 1'b0, 1'b1};
         2'h3: res = {SPD_1000, 1'b1, 1'b1};
      endcase
      return res;
   endfunction : strap_decode

   // Control fields
   logic         rst_bit_reg,  rst_bit_next;
   logic         lb_reg,       lb_next;
   logic         spd_lsb_reg,  spd_lsb_next;
   logic         spd_msb_reg,  spd_msb_next;
   logic         an_en_reg,    an_en_next;
   logic         pd_reg,       pd_next;
   logic         iso_reg,      iso_next;
   logic         an_rst_reg,   an_rst_next;
   logic         dup_reg,      dup_next;
   logic [7:0]   rst_cnt_reg,  rst_cnt_next;
   logic [1:0]   strap_cnt_reg;
   logic [1:0]   op_speed_reg;
   logic         op_dup_reg;

   // Status latches
   logic [1:0]   lh_reg,       lh_next;
   logic [1:0]   lh_seen_reg,  lh_seen_next;
   logic [1:0]   lh_cause;
   logic         ll_reg,       ll_next;

   // Management frame engine
   pbr_mdio_st_t st_reg,       st_next;
   logic [5:0]   pre_cnt_reg,  pre_cnt_next;
   logic [3:0]   bit_cnt_reg,  bit_cnt_next;
   logic [11:0]  hdr_reg,      hdr_next;
   logic [15:0]  sh_reg,       sh_next;
   logic         rd_act_reg,   rd_act_next;
   logic         wr_act_reg,   wr_act_next;
   logic         mdo_reg,      mdo_next;
   logic         oe_n_reg,     oe_n_next;
   logic         mdc_d_reg;

   logic         mdc_rise;
   logic         hdr_done;
   logic         addr_hit;
   logic         idx_ctrl;
   logic         idx_stat;
   logic         frame_end;
   logic         rd_now;
   logic         stat_rd;
   logic         ctrl_wr;
   logic [15:0]  wr_data;
   logic [15:0]  ctrl_word;
   logic [15:0]  stat_word;
   logic [15:0]  rd_word;
   logic         strap_load;
   logic         sr_done;
   logic [1:0]   forced_spd;

   localparam logic [7:0] SR_LAST = 8'(SOFT_RST_CYC - 1);

   assign mdc_rise  = mdc_s & ~mdc_d_reg;
   assign hdr_done  = mdc_rise && (st_reg == MS_HDR) && (bit_cnt_reg == HDR_LAST);
   assign hdr_next  = mdc_rise && (st_reg == MS_HDR) ? {hdr_reg[10:0], mdio_s} : hdr_reg;
   assign addr_hit  = (hdr_next[9:5] == addr_s);
   assign idx_ctrl  = (hdr_next[4:0] == CTRL_IDX);
   assign idx_stat  = (hdr_next[4:0] == STAT_IDX);
   assign rd_now    = hdr_done && addr_hit && (hdr_next[11:10] == OP_READ) && (idx_ctrl || idx_stat);
   assign stat_rd   = rd_now && idx_stat;
   assign frame_end = mdc_rise && (st_reg == MS_DATA) && (bit_cnt_reg == DATA_LAST);
   assign wr_data   = {sh_reg[14:0], mdio_s};
   assign ctrl_wr   = frame_end && wr_act_reg && (hdr_reg[4:0] == CTRL_IDX);
   assign rd_word   = idx_ctrl ? ctrl_word : stat_word;
   assign strap_load = (strap_cnt_reg == STRAP_LOAD_CYC);
   assign sr_done   = rst_bit_reg && (rst_cnt_reg == SR_LAST);
   assign forced_spd = {spd_msb_reg, spd_lsb_reg};

   // Reserved positions stay zero in both read words
   always_comb begin
      ctrl_word             = 16'h0000;
      ctrl_word[CB_RESET]   = rst_bit_reg;
      ctrl_word[CB_LOOP]    = lb_reg;
      ctrl_word[CB_SPD_LSB] = spd_lsb_reg;
      ctrl_word[CB_AN_EN]   = an_en_reg;
      ctrl_word[CB_PDOWN]   = pd_reg;
      ctrl_word[CB_ISO]     = iso_reg;
      ctrl_word[CB_AN_RST]  = an_rst_reg;
      ctrl_word[CB_DUPLEX]  = dup_reg;
      ctrl_word[CB_SPD_MSB] = spd_msb_reg;
      stat_word             = STAT_FIXED_ONES;
      stat_word[SB_AN_DONE] = an_complete;
      stat_word[SB_RFAULT]  = lh_reg[0];
      stat_word[SB_LINK]    = ll_reg;
      stat_word[SB_JABBER]  = lh_reg[1];
   end

   // Control register next state
   always_comb begin
      rst_bit_next = rst_bit_reg;
      lb_next      = lb_reg;
      spd_lsb_next = spd_lsb_reg;
      spd_msb_next = spd_msb_reg;
      an_en_next   = an_en_reg;
      pd_next      = pd_reg;
      iso_next     = iso_reg;
      dup_next     = dup_reg;
      an_rst_next  = 1'b0;
      rst_cnt_next = rst_bit_reg ? rst_cnt_reg + 8'h01 : 8'h00;
      if (strap_load) begin
         {spd_msb_next, spd_lsb_next, an_en_next, dup_next} = strap_decode(cfg_s);
      end
      if (ctrl_wr) begin
         if (wr_data[CB_RESET]) begin
            // Other bits of a reset write are dropped
            rst_bit_next = 1'b1;
         end else begin
            lb_next      = wr_data[CB_LOOP];
            spd_lsb_next = wr_data[CB_SPD_LSB];
            an_en_next   = wr_data[CB_AN_EN];
            pd_next      = wr_data[CB_PDOWN];
            iso_next     = wr_data[CB_ISO];
            dup_next     = wr_data[CB_DUPLEX];
            an_rst_next  = wr_data[CB_AN_RST];
         end
      end
      if (sr_done) begin
         rst_bit_next = 1'b0;
         lb_next      = 1'b0;
         pd_next      = 1'b0;
         iso_next     = 1'b0;
      end
   end

   // Status latches: the cause always wins over a read in the same cycle
   assign lh_cause = {jabber, remote_fault};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_lh
         assign lh_next[gi]      = lh_cause[gi] | (lh_reg[gi] & ~(lh_seen_reg[gi] | stat_rd));
         assign lh_seen_next[gi] = lh_next[gi] & (lh_seen_reg[gi] | stat_rd);
      end
   endgenerate

   assign ll_next = link_up & (ll_reg | stat_rd);

   // Management frame sequencing on each sampled clock rise
   always_comb begin
      st_next      = st_reg;
      pre_cnt_next = pre_cnt_reg;
      bit_cnt_next = bit_cnt_reg;
      sh_next      = sh_reg;
      rd_act_next  = rd_act_reg;
      wr_act_next  = wr_act_reg;
      mdo_next     = mdo_reg;
      oe_n_next    = oe_n_reg;
      if (mdc_rise) begin
         unique case (st_reg)
            MS_PRE: begin
               if (mdio_s) begin
                  if (pre_cnt_reg != PREAMBLE_LEN) begin
                     pre_cnt_next = pre_cnt_reg + 6'h01;
                  end
               end else if (pre_cnt_reg == PREAMBLE_LEN) begin
                  st_next = MS_START;
               end else begin
                  pre_cnt_next = 6'h00;
               end
            end
            MS_START: begin
               pre_cnt_next = 6'h00;
               bit_cnt_next = 4'h0;
               st_next      = mdio_s ? MS_HDR : MS_PRE;
            end
            MS_HDR: begin
               bit_cnt_next = bit_cnt_reg + 4'h1;
               if (hdr_done) begin
                  bit_cnt_next = 4'h0;
                  st_next      = MS_TA;
                  rd_act_next  = rd_now;
                  wr_act_next  = addr_hit && (hdr_next[11:10] == OP_WRITE) && idx_ctrl;
                  sh_next      = rd_now ? rd_word : 16'h0000;
               end
            end
            MS_TA: begin
               bit_cnt_next = bit_cnt_reg + 4'h1;
               oe_n_next    = ~rd_act_reg;
               mdo_next     = 1'b0;
               if (bit_cnt_reg == 4'h1) begin
                  bit_cnt_next = 4'h0;
                  st_next      = MS_DATA;
                  mdo_next     = sh_reg[15];
               end
            end
            MS_DATA: begin
               bit_cnt_next = bit_cnt_reg + 4'h1;
               sh_next      = rd_act_reg ? {sh_reg[14:0], 1'b0} : wr_data;
               mdo_next     = rd_act_reg & sh_reg[14];
               if (frame_end) begin
                  // A fresh preamble is needed before the next frame
                  st_next      = MS_PRE;
                  bit_cnt_next = 4'h0;
                  rd_act_next  = 1'b0;
                  wr_act_next  = 1'b0;
                  oe_n_next    = 1'b1;
                  mdo_next     = 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rst_bit_reg <= CTRL_BIT_RST;
         lb_reg      <= CTRL_BIT_RST;
         spd_lsb_reg <= CTRL_BIT_RST;
         spd_msb_reg <= CTRL_BIT_RST;
         an_en_reg   <= CTRL_BIT_RST;
         pd_reg      <= CTRL_BIT_RST;
         iso_reg     <= CTRL_BIT_RST;
         an_rst_reg  <= CTRL_BIT_RST;
         dup_reg     <= CTRL_BIT_RST;
         rst_cnt_reg <= 8'h00;
      end else begin
         rst_bit_reg <= rst_bit_next;
         lb_reg      <= lb_next;
         spd_lsb_reg <= spd_lsb_next;
         spd_msb_reg <= spd_msb_next;
         an_en_reg   <= an_en_next;
         pd_reg      <= pd_next;
         iso_reg     <= iso_next;
         an_rst_reg  <= an_rst_next;
         dup_reg     <= dup_next;
         rst_cnt_reg <= rst_cnt_next;
      end
   end

   // Straps are sampled a few edges after release, once the synchroniser has settled
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         strap_cnt_reg <= 2'h0;
      end else if (strap_cnt_reg != 2'h3) begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lh_reg       <= 2'h0;
         lh_seen_reg  <= 2'h0;
         ll_reg       <= 1'b0;
         op_speed_reg <= SPD_10;
         op_dup_reg   <= 1'b0;
      end else begin
         lh_reg       <= lh_next;
         lh_seen_reg  <= lh_seen_next;
         ll_reg       <= ll_next;
         // Reserved forced speed falls back to 10M
         op_speed_reg <= an_en_reg ? an_speed :
                         (forced_spd == SPD_RSVD ? SPD_10 : forced_spd);
         op_dup_reg   <= an_en_reg ? an_full_duplex : dup_reg;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg      <= MS_PRE;
         pre_cnt_reg <= 6'h00;
         bit_cnt_reg <= 4'h0;
         hdr_reg     <= 12'h000;
         sh_reg      <= 16'h0000;
         rd_act_reg  <= 1'b0;
         wr_act_reg  <= 1'b0;
         mdo_reg     <= 1'b0;
         oe_n_reg    <= 1'b1;
         mdc_d_reg   <= 1'b0;
      end else begin
         st_reg      <= st_next;
         pre_cnt_reg <= pre_cnt_next;
         bit_cnt_reg <= bit_cnt_next;
         hdr_reg     <= hdr_next;
         sh_reg      <= sh_next;
         rd_act_reg  <= rd_act_next;
         wr_act_reg  <= wr_act_next;
         mdo_reg     <= mdo_next;
         oe_n_reg    <= oe_n_next;
         mdc_d_reg   <= mdc_s;
      end
   end

   assign mdio_out       = mdo_reg;
   assign mdio_oe_n      = oe_n_reg;
   assign phy_soft_reset = rst_bit_reg;
   assign loopback_en    = lb_reg;
   assign power_down     = pd_reg;
   assign isolate_mac    = iso_reg;
   assign an_enable      = an_en_reg;
   assign an_restart     = an_rst_reg;
   assign op_speed       = op_speed_reg;
   assign op_full_duplex = op_dup_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence sr_start_s;
      $rose(rst_bit_reg);
   endsequence
   sequence sr_done_s;
      rst_bit_reg[*8] ##[1:4] !rst_bit_reg;
   endsequence

   soft_rst_self_a: assert property (sr_start_s |-> sr_done_s)
      else $error("soft reset bit did not clear itself in time");
   soft_rst_mode_a: assert property ($fell(rst_bit_reg) |-> !pd_reg && !iso_reg && !lb_reg)
      else $error("not in normal mode after soft reset");
   forced_speed_a: assert property (!an_en_reg && forced_spd == SPD_100 ##1 !an_en_reg
                                    |-> op_speed == SPD_100)
      else $error("forced speed not applied");
   an_override_a: assert property (an_en_reg |=> op_speed == $past(an_speed) &&
                                   op_full_duplex == $past(an_full_duplex))
      else $error("negotiated result not used");
   speed_msb_ro_a: assert property (ctrl_wr && !strap_load |=> $stable(spd_msb_reg))
      else $error("speed msb changed by write");
   pdown_write_a: assert property (ctrl_wr && !wr_data[CB_RESET] && !sr_done
                                   |=> pd_reg == $past(wr_data[CB_PDOWN]))
      else $error("power down did not follow write");
   an_restart_sc_a: assert property (an_rst_reg && !ctrl_wr |=> !an_rst_reg)
      else $error("restart bit did not clear itself");
   fixed_bits_a: assert property ((stat_word & 16'hffc9) == STAT_FIXED_ONES &&
                                  (ctrl_word & 16'h00bf) == 16'h0000)
      else $error("constant status or reserved bits wrong");
   lh_hold_a: assert property (lh_reg[0] && !lh_seen_reg[0] && !stat_rd |=> lh_reg[0])
      else $error("unread latch-high bit fell");
   ll_hold_a: assert property (!ll_reg && !stat_rd |=> !ll_reg)
      else $error("latched link loss released without read");
   ll_release_a: assert property (stat_rd && link_up ##1 link_up |-> ll_reg)
      else $error("read did not release latched link loss");

endmodule : pbr_regs

// >>> hdl/pbr_pkg.sv
/*
 Constants shared by the basic control and status register bank of the transceiver:
 register indices, field positions, reset values, serial management framing and timing.
 Assumes a single management clock domain at 100 MHz.
*/
package pbr_pkg;

   // Register indices on the serial management bus
   localparam logic [4:0]  CTRL_IDX        = 5'h00;
   localparam logic [4:0]  STAT_IDX        = 5'h01;

   // Control register field positions
   localparam int          CB_RESET        = 15;
   localparam int          CB_LOOP         = 14;
   localparam int          CB_SPD_LSB      = 13;
   localparam int          CB_AN_EN        = 12;
   localparam int          CB_PDOWN        = 11;
   localparam int          CB_ISO          = 10;
   localparam int          CB_AN_RST       = 9;
   localparam int          CB_DUPLEX       = 8;
   localparam int          CB_SPD_MSB      = 6;

   // Status register field positions and constant ability bits
   localparam int          SB_AN_DONE      = 5;
   localparam int          SB_RFAULT       = 4;
   localparam int          SB_LINK         = 2;
   localparam int          SB_JABBER       = 1;
   localparam logic [15:0] STAT_FIXED_ONES = 16'h7909;

   // Reset values of the single-bit control fields
   localparam logic        CTRL_BIT_RST    = 1'b0;

   // Forced speed encodings, {msb, lsb}
   localparam logic [1:0]  SPD_10          = 2'h0;
   localparam logic [1:0]  SPD_100         = 2'h1;
   localparam logic [1:0]  SPD_1000        = 2'h2;
   localparam logic [1:0]  SPD_RSVD        = 2'h3;

   // Management frame layout
   localparam logic [5:0]  PREAMBLE_LEN    = 6'h20;
   localparam logic [3:0]  HDR_LAST        = 4'hb;
   localparam logic [3:0]  DATA_LAST       = 4'hf;
   localparam logic [1:0]  OP_READ         = 2'h2;
   localparam logic [1:0]  OP_WRITE        = 2'h1;

   // Timing
   localparam int          MCLK_MHZ        = 100;
   localparam int          SOFT_RST_NS     = 100;
   localparam int          SOFT_RST_CYC    = (SOFT_RST_NS * MCLK_MHZ + 999) / 1000;
   localparam logic [1:0]  STRAP_LOAD_CYC  = 2'h2;

   typedef enum logic [2:0] {
      MS_PRE,
      MS_START,
      MS_HDR,
      MS_TA,
      MS_DATA
   } pbr_mdio_st_t;

endpackage : pbr_pkg

// >>> hdl/pbr_sync2.sv
/*
 Two flip-flop synchroniser for a group of level inputs.
 Assumes each bit is an independent slow level; no word coherence is given.
*/
`timescale 1ns/1ps
module pbr_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule : pbr_sync2

// >>> verif/pbr_smi_host.sv
/*
 Station manager model: drives management frames and samples read data.
 Assumes mclk at 100 MHz; the data wire has a pull-up.
*/
`timescale 1ns/1ps
module pbr_smi_host
   import pbr_pkg::*;
(
   input  wire logic mclk,
   input  wire logic mdio_out,
   input  wire logic mdio_oe_n,
   output logic      mdc,
   output logic      mdio_in
);
   logic host_en = 1'b0;
   logic host_d  = 1'b1;

   // Pull-up wins when nobody drives
   assign mdio_in = !mdio_oe_n ? mdio_out : (host_en ? host_d : 1'b1);

   initial begin
      mdc = 1'b0;
   end

   // One bit: change after the fall, sample at the rise; 21 mclk cycles per bit, about 4.76 MHz bit rate
   task automatic bit_io(input logic en, input logic d, output logic smp);
      @(posedge mclk) #1;
      mdc = 1'b0;
      host_en = en;
      host_d = d;
      repeat (10) @(posedge mclk);
      #1 mdc = 1'b1;
      smp = mdio_in;
      repeat (10) @(posedge mclk);
   endtask : bit_io

   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [45:0] hdr;
      logic        s;
      hdr = {32'hffffffff, 2'h1, op, pa, ra};
      for (int i = 45; i >= 0; i--) bit_io(1'b1, hdr[i], s);
      bit_io(op == OP_WRITE, 1'b1, s);
      bit_io(op == OP_WRITE, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
         bit_io(op == OP_WRITE, wd[i], s);
         rd[i] = s;
      end
      // Clock stands low between frames
      @(posedge mclk) #1;
      mdc = 1'b0;
      host_en = 1'b0;
   endtask : xfer
endmodule : pbr_smi_host

// >>> verif/pbr_regs_tb.sv
/*
 Testbench for the basic control and status registers, via management frames.
 Assumes pbr_smi_host as bus master and phy address strap 5'h05.
*/
`timescale 1ns/1ps
module pbr_regs_tb
   import pbr_pkg::*;
;
   localparam logic [4:0] MY_ADDR = 5'h05;
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic       mdc, mdio_in, mdio_out, mdio_oe_n;
   logic [1:0] mode_cfg = 2'h1;
   logic       an_complete = 1'b0, an_full_duplex = 1'b0;
   logic [1:0] an_speed = 2'h0;
   logic       remote_fault = 1'b0, link_up = 1'b0, jabber = 1'b0;
   logic       phy_soft_reset, loopback_en, power_down, isolate_mac;
   logic       an_enable, an_restart, op_full_duplex;
   logic [1:0] op_speed;
   int         err_count = 0, n_compared = 0, rst_cyc = 0, rs_cyc = 0;

   always #5 mclk = ~mclk;

   pbr_regs dut (.mclk(mclk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
      .mdio_oe_n(mdio_oe_n), .phy_addr(MY_ADDR), .mode_cfg(mode_cfg),
      .an_complete(an_complete), .an_speed(an_speed), .an_full_duplex(an_full_duplex),
      .remote_fault(remote_fault), .link_up(link_up), .jabber(jabber),
      .phy_soft_reset(phy_soft_reset), .loopback_en(loopback_en), .power_down(power_down),
      .isolate_mac(isolate_mac), .an_enable(an_enable), .an_restart(an_restart),
      .op_speed(op_speed), .op_full_duplex(op_full_duplex));

   pbr_smi_host mdm (.mclk(mclk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdc(mdc),
      .mdio_in(mdio_in));

   always @(posedge mclk) begin
      if (phy_soft_reset === 1'b1) rst_cyc++;
      if (an_restart === 1'b1) rs_cyc++;
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [15:0] d);
      logic [15:0] r;
      mdm.xfer(OP_WRITE, MY_ADDR, CTRL_IDX, d, r);
      repeat (4) @(posedge mclk);
   endtask : wr

   task automatic rd(input string what, input logic [4:0] ra, input logic [15:0] exp);
      logic [15:0] r;
      mdm.xfer(OP_READ, MY_ADDR, ra, 16'h0000, r);
      chk(what, exp, r);
   endtask : rd

   task automatic mode_chk(input logic [15:0] exp);
      chk("mode", exp, {9'h0, an_enable, loopback_en, power_down, isolate_mac, op_speed,
                        op_full_duplex});
   endtask : mode_chk

   task automatic do_reset(input logic [1:0] m);
      mode_cfg = m;
      rst = 1'b1;
      repeat (8) @(posedge mclk);
      #1 rst = 1'b0;
      repeat (8) @(posedge mclk);
      #1;
   endtask : do_reset

   task automatic complete_run;
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      do_reset(2'h1);
      rd("ctrl", CTRL_IDX, 16'h2000);
      mode_chk({13'h0, SPD_100, 1'b0});
      rd("stat", STAT_IDX, 16'h7909);
      wr(16'h01ff);
      rd("ctrl", CTRL_IDX, 16'h0100);
      mode_chk({13'h0, SPD_10, 1'b1});
      wr(16'h6d00);
      mode_chk({10'h0, 3'h7, SPD_100, 1'b1});
      wr(16'h6500);
      mode_chk({10'h0, 3'h5, SPD_100, 1'b1});
      // Power down set again so that the soft reset has something to clear
      wr(16'h6d00);
      rst_cyc = 0;
      wr(16'h8000);
      repeat (20) @(posedge mclk);
      chk("rst len", 16'(SOFT_RST_CYC), rst_cyc[15:0]);
      rd("ctrl", CTRL_IDX, 16'h2100);
      mode_chk({13'h0, SPD_100, 1'b1});
      an_speed = SPD_1000;
      an_full_duplex = 1'b1;
      rs_cyc = 0;
      wr(16'h1200);
      chk("restart", 16'h0001, rs_cyc[15:0]);
      rd("ctrl", CTRL_IDX, 16'h1000);
      mode_chk({9'h0, 1'b1, 3'h0, SPD_1000, 1'b1});
      link_up = 1'b1;
      an_complete = 1'b1;
      rd("stat", STAT_IDX, 16'h7929);
      rd("stat", STAT_IDX, 16'h792d);
      remote_fault = 1'b1;
      jabber = 1'b1;
      link_up = 1'b0;
      repeat (3) @(posedge mclk);
      #1 remote_fault = 1'b0;
      jabber = 1'b0;
      link_up = 1'b1;
      rd("stat", STAT_IDX, 16'h793b);
      jabber = 1'b1;
      rd("stat", STAT_IDX, 16'h792f);
      jabber = 1'b0;
      an_complete = 1'b0;
      rd("stat", STAT_IDX, 16'h790d);
      rd("unmapped", 5'h02, 16'hffff);
      do_reset(2'h2);
      rd("ctrl", CTRL_IDX, 16'h2100);
      do_reset(2'h0);
      rd("ctrl", CTRL_IDX, 16'h0000);
      do_reset(2'h3);
      rd("ctrl", CTRL_IDX, 16'h1140);
      wr(16'h0000);
      rd("ctrl", CTRL_IDX, 16'h0040);
      mode_chk({13'h0, SPD_1000, 1'b0});
      wr(16'h2000);
      mode_chk({13'h0, SPD_10, 1'b0});
      complete_run();
   end

   initial begin
      repeat (80000) @(posedge mclk);
      err_count++;
      complete_run();
   end
endmodule : pbr_regs_tb
